// *** include/vt_consts.svh ***
// Purpose: Constants of the line and field timing generator
// Assumes: Positions are pixel clock counts from the sync tip reference
// Notes:   Index of line length table is {field_50hz, square_pixel}
`ifndef VT_CONSTS_SVH
`define VT_CONSTS_SVH
`define VT_ADDR_CTRL     12'h000
`define VT_ADDR_HSYNC1   12'h004
`define VT_ADDR_HSYNC2   12'h008
`define VT_ADDR_HCROP    12'h00C
`define VT_ADDR_VCROP    12'h010
`define VT_ADDR_STATUS   12'h014
`define VT_MASK_CTRL     32'h00000F3F
`define VT_MASK_PAIR     32'h07FF07FF
`define VT_MASK_VCROP    32'h03FF03FF
`define VT_RST_VCROP     32'h01060015
`define VT_LEN_60C       11'h6B4
`define VT_LEN_60S       11'h618
`define VT_LEN_50C       11'h6C0
`define VT_LEN_50S       11'h760
`define VT_SYG           11'h048
`define VT_CBG_60C       11'h0DE
`define VT_CBG_60S       11'h0CC
`define VT_CBG_50C       11'h0EA
`define VT_CBG_50S       11'h0FE
`define VT_WB_60C_S      11'h09F
`define VT_WB_60C_E      11'h0FE
`define VT_WB_60S_S      11'h093
`define VT_WB_60S_E      11'h0E9
`define VT_WB_50C_S      11'h0AD
`define VT_WB_50C_E      11'h0FE
`define VT_WB_50S_S      11'h0BA
`define VT_WB_50S_E      11'h115
`define VT_FH_60C_A      11'h028
`define VT_FH_60C_B      11'h384
`define VT_FH_OTH_A      11'h02A
`define VT_FH_60S_B      11'h336
`define VT_FH_50C_B      11'h38A
`define VT_FH_50S_B      11'h3DA
`define VT_HS_START      11'h018
`define VT_HAV_60C_S     11'h125
`define VT_HAV_60C_E     11'h011
`define VT_HAV_60S_S     11'h114
`define VT_HAV_60S_E     11'h000
`define VT_HAV_50C_S     11'h141
`define VT_HAV_50C_E     11'h021
`define VT_HAV_50S_S     11'h165
`define VT_HAV_50S_E     11'h001
`define VT_HOLD_LINE     10'h104
`define VT_VBLANK_END    10'h015
`define VT_VS_HALVES     4'h6
`define VT_VS_FILT       3'h4
`endif

// *** include/vt_pkg.sv ***
// Purpose: Types of the line and field timing generator
// Assumes: Included before the timing module
// Notes:   Vertical sync states are one-hot
package vt_pkg;
  typedef logic [10:0] vt_pos_t;
  typedef enum logic [2:0] {
    VT_VS_IDLE   = 3'b001,
    VT_VS_ARM    = 3'b010,
    VT_VS_ACTIVE = 3'b100
  } vt_vs_state_e;
endpackage

// *** rtl/vt_timing.sv ***
// Purpose: Horizontal and vertical timing with field identification, APB registers
// Assumes: pclk is the line-locked pixel clock; tracker inputs are asynchronous
// Notes:   Timing outputs are registered, one clock after the counter position
// Notes on behaviour
// - 60 Hz lines wrap 1716 or 1560
// - 50 Hz lines wrap 1728 or 1888
// - Sync gate single pulse at 72
// - Burst gate single pulse per mode position
// - Wide burst window spans per mode
// - Two single pulses per line
// - Crop window polarity and edges programmable
// - Crop offsets add to default edges
// - Select zero: filtered lead, half-line trail
// - Select one: aligned lead, line-start trail
// - Shorten bit ends sync one line early
// - Vertical window from start/stop line registers
// - Odd flag on fields one, three (five, seven)
// - Odd flag follows chosen sync edge
// - Burst phase compare against threshold, polarity
// - Burst phase per line, line 260 held
// - Axis inversion in PAL at burst
// - Axis inversion line 260 held in blanking
// - Hsync offsets add to default edges
// - Line length is mode factor of line rate
`timescale 1ns/1ns
`include "vt_consts.svh"

module vt_timing
  import vt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hsync_tip_in,
  input  wire logic        vsync_detect_in,
  input  wire logic [3:0]  burst_phase_in,
  input  wire logic        v_axis_in,
  output logic             sync_gate_pulse,
  output logic             burst_gate_pulse,
  output logic             wide_burst_window,
  output logic             twice_per_line_pulse,
  output logic             primary_hsync,
  output logic             secondary_hsync,
  output logic             horizontal_active_window,
  output logic             vertical_sync,
  output logic             vertical_active_window,
  output logic             odd_field,
  output logic             burst_phase_compare,
  output logic             pal_axis_invert
);

  // Default plus offset, folded back into the line
  function automatic vt_pos_t wrap_add(vt_pos_t base, vt_pos_t off, vt_pos_t len);
    logic [11:0] s;
    s = {1'b0, base} + {1'b0, off};
    if (s >= {1'b0, len}) begin
      s = s - {1'b0, len};
    end
    if (s >= {1'b0, len}) begin
      s = s - {1'b0, len};
    end
    return s[10:0];
  endfunction

  // Inclusive window that may straddle the line wrap
  function automatic logic in_win(vt_pos_t h, vt_pos_t s, vt_pos_t e);
    return (s <= e) ? (h >= s && h <= e) : (h >= s || h <= e);
  endfunction

  // Registers
  logic [31:0]  ctrl;
  logic [31:0]  hsync1;
  logic [31:0]  hsync2;
  logic [31:0]  hcrop;
  logic [31:0]  vcrop;
  logic [31:0]  next_ctrl;
  logic [31:0]  next_hsync1;
  logic [31:0]  next_hsync2;
  logic [31:0]  next_hcrop;
  logic [31:0]  next_vcrop;
  logic [31:0]  next_prdata;
  logic         next_pready;
  logic         next_pslverr;
  logic         wr_go;
  logic [1:0]   mode;
  logic         pal;
  logic         align;
  logic         shorten;
  logic         hav_pol;
  logic [3:0]   thr;

  // Synchronisers, a third stage only for edge detection
  logic         tip_s1, tip_s2, tip_s3;
  logic         det_s1, det_s2;
  logic [3:0]   bp_s1, bp_s2;
  logic         ax_s1, ax_s2;
  logic         tip_rise;

  // Horizontal state
  vt_pos_t      hcount;
  vt_pos_t      next_hcount;
  vt_pos_t      len_cur, cbg_cur, wb_s, wb_e, fh_a, fh_b, hav_s, hav_e;
  logic         next_syg, next_cbg, next_wb, next_fh, next_hs1, next_hs2, next_hav;
  logic         line_start;
  logic         half_pt;

  // Vertical state
  vt_vs_state_e vs_state, next_vs_state;
  logic [9:0]   line_cnt, next_line_cnt;
  logic [3:0]   half_cnt, next_half_cnt;
  logic [2:0]   field, next_field;
  logic [2:0]   filt, next_filt;
  logic         next_vs, next_odd, next_vav, next_bp, next_pid;
  logic         det_fire;
  logic         half_evt;
  logic         vs_end;
  logic         capture;
  logic [3:0]   vs_target;

  assign mode    = ctrl[1:0];
  assign pal     = ctrl[2];
  assign align   = ctrl[3];
  assign shorten = ctrl[4];
  assign hav_pol = ctrl[5];
  assign thr     = ctrl[11:8];
  assign wr_go   = psel & penable & pready & pwrite;

  // APB slave: no wait state, answer registered from the setup phase
  always_comb begin
    next_ctrl    = ctrl;
    next_hsync1  = hsync1;
    next_hsync2  = hsync2;
    next_hcrop   = hcrop;
    next_vcrop   = vcrop;
    next_pready  = psel & ~penable;
    next_pslverr = 1'b0;
    next_prdata  = 32'h00000000;
    if (wr_go) begin
      unique case (paddr)
        `VT_ADDR_CTRL:   next_ctrl   = pwdata & `VT_MASK_CTRL;
        `VT_ADDR_HSYNC1: next_hsync1 = pwdata & `VT_MASK_PAIR;
        `VT_ADDR_HSYNC2: next_hsync2 = pwdata & `VT_MASK_PAIR;
        `VT_ADDR_HCROP:  next_hcrop  = pwdata & `VT_MASK_PAIR;
        `VT_ADDR_VCROP:  next_vcrop  = pwdata & `VT_MASK_VCROP;
        default:         next_ctrl   = ctrl;
      endcase
    end
    if (psel & ~penable) begin
      unique case (paddr)
        `VT_ADDR_CTRL:   next_prdata = ctrl;
        `VT_ADDR_HSYNC1: next_prdata = hsync1;
        `VT_ADDR_HSYNC2: next_prdata = hsync2;
        `VT_ADDR_HCROP:  next_prdata = hcrop;
        `VT_ADDR_VCROP:  next_prdata = vcrop;
        `VT_ADDR_STATUS: next_prdata = {odd_field, vertical_sync, 1'b0, field,
                                        line_cnt, 5'h00, hcount};
        default:         next_pslverr = 1'b1;
      endcase
    end
  end

  // Register file and bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= 32'h00000000;
      hsync1  <= 32'h00000000;
      hsync2  <= 32'h00000000;
      hcrop   <= 32'h00000000;
      vcrop   <= `VT_RST_VCROP;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      hsync1  <= next_hsync1;
      hsync2  <= next_hsync2;
      hcrop   <= next_hcrop;
      vcrop   <= next_vcrop;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Pin synchronisers; the second stage feeds logic, the third only the sync tip edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tip_s1 <= 1'b0;
      tip_s2 <= 1'b0;
      tip_s3 <= 1'b0;
      det_s1 <= 1'b0;
      det_s2 <= 1'b0;
      bp_s1  <= 4'h0;
      bp_s2  <= 4'h0;
      ax_s1  <= 1'b0;
      ax_s2  <= 1'b0;
    end else begin
      tip_s1 <= hsync_tip_in;
      tip_s2 <= tip_s1;
      tip_s3 <= tip_s2;
      det_s1 <= vsync_detect_in;
      det_s2 <= det_s1;
      bp_s1  <= burst_phase_in;
      bp_s2  <= bp_s1;
      ax_s1  <= v_axis_in;
      ax_s2  <= ax_s1;
    end
  end
  assign tip_rise = tip_s2 & ~tip_s3;

  // Per-mode default edges
  // line length factor
  always_comb begin
    unique case (mode)
      2'h0: begin
        len_cur = `VT_LEN_60C; cbg_cur = `VT_CBG_60C;
        wb_s = `VT_WB_60C_S; wb_e = `VT_WB_60C_E; fh_a = `VT_FH_60C_A; fh_b = `VT_FH_60C_B;
        hav_s = `VT_HAV_60C_S; hav_e = `VT_HAV_60C_E;
      end
      2'h1: begin
        len_cur = `VT_LEN_60S; cbg_cur = `VT_CBG_60S;
        wb_s = `VT_WB_60S_S; wb_e = `VT_WB_60S_E; fh_a = `VT_FH_OTH_A; fh_b = `VT_FH_60S_B;
        hav_s = `VT_HAV_60S_S; hav_e = `VT_HAV_60S_E;
      end
      2'h2: begin
        len_cur = `VT_LEN_50C; cbg_cur = `VT_CBG_50C;
        wb_s = `VT_WB_50C_S; wb_e = `VT_WB_50C_E; fh_a = `VT_FH_OTH_A; fh_b = `VT_FH_50C_B;
        hav_s = `VT_HAV_50C_S; hav_e = `VT_HAV_50C_E;
      end
      2'h3: begin
        len_cur = `VT_LEN_50S; cbg_cur = `VT_CBG_50S;
        wb_s = `VT_WB_50S_S; wb_e = `VT_WB_50S_E; fh_a = `VT_FH_OTH_A; fh_b = `VT_FH_50S_B;
        hav_s = `VT_HAV_50S_S; hav_e = `VT_HAV_50S_E;
      end
    endcase
  end

  // Horizontal counter and gates; the sync tip restarts the count at zero
  always_comb begin
    line_start = tip_rise | (hcount == len_cur - 11'h001);
    half_pt    = hcount == ((len_cur >> 1) - 11'h001);
    next_hcount = line_start ? 11'h000 : hcount + 11'h001;
    next_syg = hcount == `VT_SYG;
    next_cbg = hcount == cbg_cur;
    next_wb  = in_win(hcount, wb_s, wb_e);
    next_fh  = (hcount == fh_a) | (hcount == fh_b);
    next_hs1 = in_win(hcount, wrap_add(`VT_HS_START, hsync1[10:0], len_cur),
                      wrap_add(cbg_cur, hsync1[26:16], len_cur));
    next_hs2 = in_win(hcount, wrap_add(`VT_HS_START, hsync2[10:0], len_cur),
                      wrap_add(cbg_cur, hsync2[26:16], len_cur));
    next_hav = hav_pol ^ in_win(hcount, wrap_add(hav_s, hcrop[10:0], len_cur),
                                wrap_add(hav_e, hcrop[26:16], len_cur));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcount                   <= 11'h000;
      sync_gate_pulse          <= 1'b0;
      burst_gate_pulse         <= 1'b0;
      wide_burst_window        <= 1'b0;
      twice_per_line_pulse     <= 1'b0;
      primary_hsync            <= 1'b0;
      secondary_hsync          <= 1'b0;
      horizontal_active_window <= 1'b0;
    end else begin
      hcount                   <= next_hcount;
      sync_gate_pulse          <= next_syg;
      burst_gate_pulse         <= next_cbg;
      wide_burst_window        <= next_wb;
      twice_per_line_pulse     <= next_fh;
      primary_hsync            <= next_hs1;
      secondary_hsync          <= next_hs2;
      horizontal_active_window <= next_hav;
    end
  end

  // Vertical sync, lines, field count and field identification
  always_comb begin
    next_vs_state = vs_state;
    next_line_cnt = line_cnt;
    next_half_cnt = half_cnt;
    next_field    = field;
    next_odd      = odd_field;
    next_vs       = vertical_sync;
    next_filt     = filt;
    // Low-pass on the detector: needs a run of high samples, noise restarts it
    if (!det_s2) begin
      next_filt = 3'h0;
    end else if (filt != `VT_VS_FILT) begin
      next_filt = filt + 3'h1;
    end
    det_fire  = det_s2 && (filt == `VT_VS_FILT - 3'h1);
    half_evt  = line_start | half_pt;
    vs_target = shorten ? `VT_VS_HALVES - 4'h2 : `VT_VS_HALVES;
    if (line_start && line_cnt != 10'h3FF) begin
      next_line_cnt = line_cnt + 10'h001;
    end
    vs_end = 1'b0;
    unique case (vs_state)
      VT_VS_IDLE: begin
        if (det_fire) begin
          next_vs_state = align ? VT_VS_ARM : VT_VS_ACTIVE;
          next_vs       = ~align;
        end
      end
      VT_VS_ARM: begin
        if (half_evt) begin
          next_vs_state = VT_VS_ACTIVE;
          next_vs       = 1'b1;
        end
      end
      VT_VS_ACTIVE: begin
        if (half_evt) begin
          next_half_cnt = half_cnt + 4'h1;
        end
        vs_end = (align ? line_start : half_evt) && (half_cnt + 4'h1 >= vs_target);
        if (vs_end) begin
          next_vs_state = VT_VS_IDLE;
          next_vs       = 1'b0;
        end
      end
    endcase
    // Leading edge: restart line count, advance field (modulo 4, or 8 in PAL)
    if (next_vs && !vertical_sync) begin
      next_line_cnt = 10'h001;
      next_half_cnt = 4'h0;
      next_field    = pal ? field + 3'h1 : {1'b0, field[1:0] + 2'h1};
      if (align) begin
        next_odd = ~next_field[0];
      end
    end
    if (vs_end && !align) begin
      next_odd = ~field[0];
    end
    next_vav = (line_cnt >= vcrop[9:0]) && (line_cnt <= vcrop[25:16]);
    capture  = next_cbg && ((line_cnt > `VT_VBLANK_END - 10'h001 &&
                line_cnt < `VT_HOLD_LINE) || line_cnt == `VT_HOLD_LINE);
    next_bp  = burst_phase_compare;
    next_pid = pal_axis_invert;
    if (capture) begin
      next_bp  = (bp_s2 > thr) ^ thr[3];
      next_pid = pal & ax_s2;
    end
    if (!pal) begin
      next_pid = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vs_state               <= VT_VS_IDLE;
      line_cnt               <= 10'h001;
      half_cnt               <= 4'h0;
      field                  <= 3'h0;
      filt                   <= 3'h0;
      vertical_sync          <= 1'b0;
      odd_field              <= 1'b1;
      vertical_active_window <= 1'b0;
      burst_phase_compare    <= 1'b0;
      pal_axis_invert        <= 1'b0;
    end else begin
      vs_state               <= next_vs_state;
      line_cnt               <= next_line_cnt;
      half_cnt               <= next_half_cnt;
      field                  <= next_field;
      filt                   <= next_filt;
      vertical_sync          <= next_vs;
      odd_field              <= next_odd;
      vertical_active_window <= next_vav;
      burst_phase_compare    <= next_bp;
      pal_axis_invert        <= next_pid;
    end
  end

  // Checks next to the logic they guard
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_hcount_wrap: assert property ((hcount == len_cur - 11'h001) && !tip_rise |=> hcount == 11'h000)
    else $error("horizontal counter missed its wrap");
  a_hcount_len: assert property ((mode == 2'h3) && $stable(mode) && !tip_rise && hcount == 11'h75F |=> hcount == 11'h000)
    else $error("50 Hz square pixel line length wrong");
  a_sync_gate_pos: assert property (sync_gate_pulse |-> $past(hcount) == 11'h048 ##1 !sync_gate_pulse)
    else $error("sync gate at wrong count or too long");
  a_burst_gate_pos: assert property (burst_gate_pulse |-> $past(hcount) == $past(cbg_cur))
    else $error("burst gate at wrong count");
  a_wide_burst_span: assert property ((mode == 2'h0) && hcount == 11'h09F |=> wide_burst_window)
    else $error("wide burst window not open at its start");
  a_twice_pulse: assert property (twice_per_line_pulse |-> ($past(hcount) == $past(fh_a)) || ($past(hcount) == $past(fh_b)))
    else $error("twice per line pulse misplaced");
  a_vs_trail_line: assert property ($fell(vertical_sync) && $past(align) |-> $past(line_start))
    else $error("aligned vertical sync did not end at line start");
  a_vav_window: assert property ((line_cnt == vcrop[9:0]) && $stable(vcrop) && vcrop[9:0] <= vcrop[25:16] |=> vertical_active_window)
    else $error("vertical window not open on its start line");
  a_odd_lead: assert property ($changed(odd_field) && $past(align) |-> $rose(vertical_sync))
    else $error("odd flag moved away from sync lead");
  a_bp_hold: assert property ((line_cnt > 10'h104 || line_cnt < 10'h015)
      |=> $stable(burst_phase_compare))
    else $error("burst phase changed during blanking hold");
  a_pid_hold: assert property ((line_cnt > 10'h104 || line_cnt < 10'h015) && pal
      |=> $stable(pal_axis_invert))
    else $error("axis inversion changed during blanking hold");
  a_pid_ntsc: assert property (!pal |=> !pal_axis_invert)
    else $error("axis inversion set outside PAL");

  c_vs_pulse: cover property ($rose(vertical_sync) ##1 vertical_sync);
  c_vs_short: cover property (shorten && $fell(vertical_sync));
  c_apb_write: cover property (wr_go && paddr == `VT_ADDR_HCROP);
  c_odd_toggle: cover property ($changed(odd_field));

endmodule

// *** sim/vt_field_latch.sv ***
// Purpose: Downstream consumer model that latches the field identity
// Assumes: Field signals have settled by the time vertical sync falls
// Notes:   Bit 2 odd flag, bit 1 burst phase, bit 0 axis inversion
`timescale 1ns/1ns

module vt_field_latch (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       vertical_sync,
  input  wire logic       odd_field,
  input  wire logic       burst_phase_compare,
  input  wire logic       pal_axis_invert,
  output logic      [2:0] field_id
);
  logic vs_d;

  // latch at trail
  // Burst phase and axis change at other times, and the odd flag on the trailing edge at the latest, so only that edge is safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vs_d     <= 1'h0;
      field_id <= 3'h0;
    end else begin
      vs_d <= vertical_sync;
      if (vs_d && !vertical_sync) begin
        field_id <= {odd_field, burst_phase_compare, pal_axis_invert};
      end
    end
  end
endmodule

// *** sim/video_line_field_timing_test.sv ***
// Purpose: Self-checking bench of the line and field timing generator
// Assumes: Register map and latencies as handed over with the design
// Notes:   Sync tip input stays low, so lines free-run at the mode length
`timescale 1ns/1ns
`include "vt_consts.svh"

module video_line_field_timing_test;
  logic        pclk            = 1'h0;
  logic        presetn         = 1'h0;
  logic        psel            = 1'h0;
  logic        penable         = 1'h0;
  logic        pwrite          = 1'h0;
  logic [11:0] paddr           = 12'h000;
  logic [31:0] pwdata          = 32'h0;
  logic        hsync_tip_in    = 1'h0;
  logic        vsync_detect_in = 1'h0;
  logic [3:0]  burst_phase_in  = 4'h0;
  logic        v_axis_in       = 1'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sync_gate_pulse;
  logic        burst_gate_pulse;
  logic        wide_burst_window;
  logic        twice_per_line_pulse;
  logic        primary_hsync;
  logic        secondary_hsync;
  logic        horizontal_active_window;
  logic        vertical_sync;
  logic        vertical_active_window;
  logic        odd_field;
  logic        burst_phase_compare;
  logic        pal_axis_invert;
  logic [2:0]  field_id;
  logic [31:0] rdat;
  logic        rerr;
  logic        o_pre;
  logic        o_in;
  logic        o_post;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  int          len_c, bg_at, tp_c, tp_at, wb_c, hs1_c, hs2_c, hav_c;
  int          hi, h1, lead, trail, vv;
  // Per-mode figures, positions taken relative to the sync gate
  int          len_t [4] = '{1716, 1560, 1728, 1888};
  int          bg_t  [4] = '{150, 132, 162, 182};
  int          tp_t  [4] = '{2512, 2280, 2532, 2772};
  int          wb_t  [4] = '{96, 87, 82, 92};
  int          hs_t  [4] = '{199, 181, 211, 231};
  int          hav_t [4] = '{1441, 1285, 1441, 1533};
  logic [3:0]  ph_t  [4] = '{4'h5, 4'h5, 4'hA, 4'h2};
  logic [3:0]  th_t  [4] = '{4'h3, 4'h9, 4'h9, 4'h3};
  logic        bx_t  [4] = '{1'h1, 1'h1, 1'h0, 1'h0};

  vt_timing dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hsync_tip_in, .vsync_detect_in, .burst_phase_in, .v_axis_in,
    .sync_gate_pulse, .burst_gate_pulse, .wide_burst_window, .twice_per_line_pulse,
    .primary_hsync, .secondary_hsync, .horizontal_active_window, .vertical_sync,
    .vertical_active_window, .odd_field, .burst_phase_compare, .pal_axis_invert);

  vt_field_latch sink (.pclk, .presetn, .vertical_sync, .odd_field, .burst_phase_compare,
    .pal_axis_invert, .field_id);

  // Free-running pixel clock, 10 ns period
  always #5 pclk = ~pclk;

  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tmo();
    n_mismatch++;
    $display("MISMATCH %0t wait ran out", $time);
    close_out();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) tmo();
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdat, e);
  endtask

  // Measures one line from sync gate to sync gate; counts taken per cycle
  task automatic line_meas();
    int k;
    k = 0;
    while (sync_gate_pulse !== 1'h1) begin
      @(negedge pclk);
      k++;
      if (k > 4000) tmo();
    end
    len_c = 0;
    bg_at = 0;
    tp_c  = 0;
    tp_at = 0;
    wb_c  = 0;
    hs1_c = 0;
    hs2_c = 0;
    hav_c = 0;
    do begin
      @(negedge pclk);
      len_c++;
      bg_at += len_c * burst_gate_pulse;
      tp_c  += twice_per_line_pulse;
      tp_at += len_c * twice_per_line_pulse;
      wb_c  += wide_burst_window;
      hs1_c += primary_hsync;
      hs2_c += secondary_hsync;
      hav_c += horizontal_active_window;
    end while (sync_gate_pulse !== 1'h1 && len_c < 4000);
  endtask

  // Edge seen at position p lies within two clocks of a multiple of m
  function automatic logic near(input int p, input int m);
    int a;
    a = (p + 73) % m;
    return (a <= 2 || a >= m - 2);
  endfunction

  // Raises the raw detection briefly, then follows one whole vertical sync
  task automatic vs_run(input logic [31:0] c);
    int k;
    int pos;
    int post_k;
    wr(`VT_ADDR_CTRL, c);
    line_meas();
    o_pre = odd_field;
    @(posedge pclk);
    vsync_detect_in <= 1'h1;
    repeat (20) @(posedge pclk);
    vsync_detect_in <= 1'h0;
    k      = 0;
    pos    = 20;
    hi     = 0;
    lead   = -1;
    trail  = -1;
    post_k = 0;
    vv     = 0;
    while (!(trail >= 0 && k > post_k + 2000)) begin
      @(negedge pclk);
      k++;
      pos++;
      if (sync_gate_pulse === 1'h1) pos = 0;
      vv += vertical_active_window;
      if (vertical_sync === 1'h1) begin
        if (hi == 0) lead = pos;
        hi++;
        if (hi == 3) o_in = odd_field;
      end else if (hi > 0 && trail < 0) begin
        trail  = pos;
        post_k = k;
      end
      if (trail >= 0 && k == post_k + 3) o_post = odd_field;
      if (k > 16000) tmo();
    end
  endtask

  // Main sequence: registers, line timing per mode, crop, field signals
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd(`VT_ADDR_VCROP, `VT_RST_VCROP);
    rd(`VT_ADDR_HCROP, 32'h0);
    rd(12'h018, 32'h0);
    chk(rerr, 1'h1);
    wr(`VT_ADDR_CTRL, 32'hFFFFFFFF);
    rd(`VT_ADDR_CTRL, `VT_MASK_CTRL);
    for (int i = 0; i < 4; i++) begin
      wr(`VT_ADDR_CTRL, i);
      line_meas();
      line_meas();
      chk(len_c, len_t[i]);
      chk(bg_at, bg_t[i]);
      chk(tp_c, 32'h2);
      chk(tp_at, tp_t[i]);
      chk(wb_c, wb_t[i]);
      chk(hs1_c, hs_t[i]);
      chk(hav_c, hav_t[i]);
    end
    wr(`VT_ADDR_CTRL, 32'h0);
    wr(`VT_ADDR_HSYNC1, 32'h00040002);
    wr(`VT_ADDR_HSYNC2, 32'h000006A4);
    wr(`VT_ADDR_HCROP, 32'h00080004);
    line_meas();
    chk(hs1_c, 201);
    chk(hs2_c, 215);
    chk(hav_c, 1445);
    wr(`VT_ADDR_CTRL, 32'h20);
    v_axis_in <= 1'h1;
    line_meas();
    chk(hav_c, 271);
    repeat (10) line_meas();
    for (int i = 0; i < 4; i++) begin
      wr(`VT_ADDR_CTRL, {20'h0, th_t[i], 5'h0, i[0], 2'h0});
      burst_phase_in <= ph_t[i];
      line_meas();
      line_meas();
      chk(burst_phase_compare, bx_t[i]);
      chk(pal_axis_invert, i[0]);
    end
    wr(`VT_ADDR_VCROP, 32'h00040002);
    vs_run(32'h18);
    h1 = hi;
    chk(near(lead, 858), 1'h1);
    chk(near(trail, 1716), 1'h1);
    chk(o_in, !o_pre);
    chk(vv, 5148);
    vs_run(32'h08);
    chk(hi - h1, 1716);
    chk(o_post, !o_pre);
    chk(field_id[2], o_post);
    // Blanking lines only: a fresh phase or axis must not be taken up
    burst_phase_in <= 4'h0;
    vs_run(32'h04);
    chk(near(trail, 858), 1'h1);
    chk(o_in, o_pre);
    chk(o_post, !o_pre);
    chk(burst_phase_compare, 1'h1);
    chk(pal_axis_invert, 1'h0);
    apb(1'h0, `VT_ADDR_STATUS, 32'h0);
    chk(rdat & 32'hFC000000, 32'h0C000000);
    close_out();
  end
endmodule
